// ---- shared/acsg_defines.vh ----
`ifndef ACSG_DEFINES_VH
`define ACSG_DEFINES_VH
// port filter modes
`define ACSG_PMODE_ANY 2'h0
`define ACSG_PMODE_SPEC 2'h1
`define ACSG_PMODE_RANGE 2'h2
// tcp flag selector codes
`define ACSG_FLAG_ZERO 2'h0
`define ACSG_FLAG_ONE 2'h1
`define ACSG_FLAG_ANY 2'h2
// flag bit positions in the parsed flag byte
`define ACSG_BIT_FIN 0
`define ACSG_BIT_SYN 1
`define ACSG_BIT_RST 2
`define ACSG_BIT_PSH 3
`define ACSG_BIT_ACK 4
`define ACSG_BIT_URG 5
// ethertype limits and refused codes
`define ACSG_ETYPE_MIN 16'h0600
`define ACSG_ETYPE_IPV4 16'h0800
`define ACSG_ETYPE_ARP 16'h0806
`define ACSG_ETYPE_IPV6 16'h86dd
// dynamic client limit codes
`define ACSG_LIM_0 2'h0
`define ACSG_LIM_1 2'h1
`define ACSG_LIM_2 2'h2
`define ACSG_LIM_UNL 2'h3
// reset values
`define ACSG_RST_PMODE 2'h0
`define ACSG_RST_FLAG 2'h2
`endif

// ---- core/acsg_port_guard.v ----
`include "acsg_defines.vh"

// per-port dynamic binding counter and forwarding gate
module acsg_port_guard #(
    parameter CW = 8
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // configuration
    input wire active,
    input wire [1:0] dyn_limit,
    // binding events
    input wire learn_req,
    input wire remove_req,
    input wire convert_cmd,
    // frame qualifiers
    input wire is_ip,
    input wire static_hit,
    input wire dynamic_hit,
    // results
    output wire learn_ok,
    output wire forward_ok,
    output wire [CW-1:0] dyn_count
);
    reg [CW-1:0] count_ff;
    reg [CW-1:0] nxt_count;
    reg at_limit;

    // limit check; unlimited saturates at an all-ones count
    always @* begin
        case (dyn_limit)
            `ACSG_LIM_0: at_limit = 1'b1; // R18
            `ACSG_LIM_1: at_limit = (count_ff >= 1);
            `ACSG_LIM_2: at_limit = (count_ff >= 2);
            default: at_limit = (count_ff == {CW{1'b1}});
        endcase
    end

    assign learn_ok = learn_req & ~at_limit; // R22

    // convert moves all dynamic entries to static, emptying the count
    always @* begin
        nxt_count = count_ff;
        if (convert_cmd) begin
            nxt_count = {CW{1'b0}}; // R20
        end else if (learn_ok && !remove_req) begin
            nxt_count = count_ff + 1'b1;
        end else if (remove_req && !learn_ok && count_ff != 0) begin
            nxt_count = count_ff - 1'b1; // R22
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            count_ff <= {CW{1'b0}};
        end else begin
            count_ff <= nxt_count;
        end
    end

    // non-ip traffic is not the guard's business
    assign forward_ok = ~active | ~is_ip | static_hit |
        ((dyn_limit != `ACSG_LIM_0) & dynamic_hit); // R19
    assign dyn_count = count_ff;
endmodule

// ---- core/acsg_classifier.v ----
//
// Functional notes
// R1: source any ignores source port
// R2: source specific matches equal port
// R3: source range matches port within bounds
// R4: destination any ignores destination port
// R5: destination specific matches equal port
// R6: destination range matches port within bounds
// R7: fin selector zero, one or any
// R8: syn selector zero, one or any
// R9: rst selector zero, one or any
// R10: psh selector zero, one or any
// R11: ack selector zero, one or any
// R12: urg selector zero, one or any
// R13: ethertype any ignores frame ethertype
// R14: specific ethertype from 0x600, equality match
// R15: ipv4, arp, ipv6 codes refused as value
// R16: global enable rising clears the entry
// R17: guard active needs global and port enable
// R18: per-port limit zero, one, two, unlimited; the code stops unlimited learning at an all-ones count
// R19: limit zero forwards only static-bound ip
// R20: convert turns dynamic bindings into static
// R21: match needs every cared field satisfied
// R22: learning refused at limit, bindings kept
//
`include "acsg_defines.vh"

module acsg_classifier #(
    parameter NPORTS = 4,
    parameter CW = 8
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // entry configuration, taken when cfg_write is high
    input wire cfg_write,
    input wire [1:0] cfg_src_mode,
    input wire [15:0] cfg_src_lo,
    input wire [15:0] cfg_src_hi,
    input wire [1:0] cfg_dst_mode,
    input wire [15:0] cfg_dst_lo,
    input wire [15:0] cfg_dst_hi,
    input wire [11:0] cfg_flag_sel,
    input wire cfg_etype_spec,
    input wire [15:0] cfg_etype_val,
    // entry status
    output reg entry_valid,
    output reg cfg_reject,
    // parsed frame from the forwarding pipeline
    input wire frm_valid,
    input wire [15:0] frm_etype,
    input wire frm_is_tcp,
    input wire frm_is_l4,
    input wire [15:0] frm_src_port,
    input wire [15:0] frm_dst_port,
    input wire [5:0] frm_tcp_flags,
    input wire [NPORTS-1:0] frm_port_onehot,
    input wire frm_is_ip,
    input wire frm_static_hit,
    input wire frm_dynamic_hit,
    // classification result
    output reg res_valid,
    output reg res_match,
    output reg res_forward,
    // source guard configuration
    input wire guard_global_en,
    input wire [NPORTS-1:0] guard_port_en,
    input wire [2*NPORTS-1:0] guard_dyn_limit,
    input wire convert_cmd,
    // binding learning
    input wire [NPORTS-1:0] learn_req,
    input wire [NPORTS-1:0] remove_req,
    output wire [NPORTS-1:0] learn_ok,
    output wire [NPORTS-1:0] guard_active,
    output wire [CW*NPORTS-1:0] dyn_count
);
    ////////////////////////////////////////////////////////////////////////
    // stored entry
    reg [1:0] src_mode_ff, dst_mode_ff;
    reg [15:0] src_lo_ff, src_hi_ff, dst_lo_ff, dst_hi_ff;
    reg [11:0] flag_sel_ff;
    reg etype_spec_ff;
    reg [15:0] etype_val_ff;
    reg valid_ff, reject_ff, glob_ff;
    wire etype_bad;
    wire glob_rise;

    // port criterion; bounds inclusive, swapped bounds never match
    function port_ok;
        input [1:0] mode;
        input [15:0] lo;
        input [15:0] hi;
        input [15:0] port;
        begin
            case (mode)
                `ACSG_PMODE_ANY: port_ok = 1'b1;
                `ACSG_PMODE_SPEC: port_ok = (port == lo);
                `ACSG_PMODE_RANGE: port_ok = (port >= lo) && (port <= hi);
                default: port_ok = 1'b0;
            endcase
        end
    endfunction

    // flag criterion
    function flag_ok;
        input [1:0] sel;
        input bit_val;
        begin
            case (sel)
                `ACSG_FLAG_ZERO: flag_ok = ~bit_val;
                `ACSG_FLAG_ONE: flag_ok = bit_val;
                default: flag_ok = 1'b1;
            endcase
        end
    endfunction

    // value check; the three refused codes keep the old entry
    assign etype_bad = cfg_etype_spec &&
        ((cfg_etype_val < `ACSG_ETYPE_MIN) ||
         (cfg_etype_val == `ACSG_ETYPE_IPV4) ||
         (cfg_etype_val == `ACSG_ETYPE_ARP) ||
         (cfg_etype_val == `ACSG_ETYPE_IPV6)); // R14 R15
    assign glob_rise = guard_global_en & ~glob_ff;

    // entry storage; the enable edge wins over a same-cycle write
    always @(posedge clock) begin
        if (rst) begin
            src_mode_ff <= `ACSG_RST_PMODE;
            dst_mode_ff <= `ACSG_RST_PMODE;
            src_lo_ff <= 16'h0000;
            src_hi_ff <= 16'h0000;
            dst_lo_ff <= 16'h0000;
            dst_hi_ff <= 16'h0000;
            flag_sel_ff <= {6{`ACSG_RST_FLAG}};
            etype_spec_ff <= 1'b0;
            etype_val_ff <= 16'h0000;
            valid_ff <= 1'b0;
            reject_ff <= 1'b0;
            glob_ff <= 1'b0;
        end else begin
            glob_ff <= guard_global_en;
            if (glob_rise) begin
                valid_ff <= 1'b0; // R16
                src_mode_ff <= `ACSG_RST_PMODE;
                dst_mode_ff <= `ACSG_RST_PMODE;
                flag_sel_ff <= {6{`ACSG_RST_FLAG}};
                etype_spec_ff <= 1'b0;
            end else if (cfg_write) begin
                reject_ff <= etype_bad; // R15
                if (!etype_bad) begin
                    src_mode_ff <= cfg_src_mode;
                    src_lo_ff <= cfg_src_lo;
                    src_hi_ff <= cfg_src_hi;
                    dst_mode_ff <= cfg_dst_mode;
                    dst_lo_ff <= cfg_dst_lo;
                    dst_hi_ff <= cfg_dst_hi;
                    flag_sel_ff <= cfg_flag_sel;
                    etype_spec_ff <= cfg_etype_spec;
                    etype_val_ff <= cfg_etype_val;
                    valid_ff <= 1'b1;
                end
            end
        end
    end

    always @* begin
        entry_valid = valid_ff;
        cfg_reject = reject_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // match evaluation
    wire src_hit, dst_hit, etype_hit;
    wire [5:0] flag_hit;
    wire flags_all;
    wire match_now;

    // non-l4 frames carry no ports and fail a port criterion
    assign src_hit = (src_mode_ff == `ACSG_PMODE_ANY) ||
        (frm_is_l4 && port_ok(src_mode_ff, src_lo_ff, src_hi_ff,
        frm_src_port)); // R1 R2 R3
    assign dst_hit = (dst_mode_ff == `ACSG_PMODE_ANY) ||
        (frm_is_l4 && port_ok(dst_mode_ff, dst_lo_ff, dst_hi_ff,
        frm_dst_port)); // R4 R5 R6

    // one selector per flag: fin syn rst psh ack urg
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
            assign flag_hit[gi] = flag_ok(flag_sel_ff[2*gi+1:2*gi],
                frm_tcp_flags[gi]); // R7 R8 R9 R10 R11 R12
        end
    endgenerate

    // flag criteria only bite on tcp frames
    assign flags_all = ~frm_is_tcp | (&flag_hit);
    assign etype_hit = ~etype_spec_ff ||
        (frm_etype == etype_val_ff); // R13 R14
    assign match_now = valid_ff & src_hit & dst_hit & flags_all &
        etype_hit; // R21

    ////////////////////////////////////////////////////////////////////////
    // source guard per port
    wire [NPORTS-1:0] fwd_vec;
    wire [NPORTS-1:0] frm_on_port;

    generate
        for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
            assign guard_active[gi] = guard_global_en &
                guard_port_en[gi]; // R17
            assign frm_on_port[gi] = frm_valid & frm_port_onehot[gi];
            acsg_port_guard #(
                .CW(CW)
            ) u_guard (
                .clock(clock),
                .rst(rst),
                .active(guard_active[gi]),
                .dyn_limit(guard_dyn_limit[2*gi+1:2*gi]), // R18
                .learn_req(learn_req[gi] & guard_active[gi]),
                .remove_req(remove_req[gi]),
                .convert_cmd(convert_cmd), // R20
                .is_ip(frm_is_ip & frm_on_port[gi]),
                .static_hit(frm_static_hit),
                .dynamic_hit(frm_dynamic_hit),
                .learn_ok(learn_ok[gi]),
                .forward_ok(fwd_vec[gi]), // R19
                .dyn_count(dyn_count[CW*gi+CW-1:CW*gi])
            );
        end
    endgenerate

    // registered result, one cycle after the frame strobe
    always @(posedge clock) begin
        if (rst) begin
            res_valid <= 1'b0;
            res_match <= 1'b0;
            res_forward <= 1'b0;
        end else begin
            res_valid <= frm_valid;
            res_match <= frm_valid & match_now;
            res_forward <= frm_valid & (&fwd_vec);
        end
    end
endmodule

// ---- test/acsg_pipe_model.sv ----
// frame source standing in for the forwarding pipeline
module acsg_pipe_model #(
    parameter NPORTS = 4
) (
    // clock
    input wire clock,
    // parsed frame
    output logic frm_valid,
    output logic [15:0] frm_etype,
    output logic [15:0] frm_src_port,
    output logic [15:0] frm_dst_port,
    output logic [5:0] frm_tcp_flags,
    output logic frm_is_tcp,
    output logic frm_is_l4,
    output logic frm_is_ip,
    output logic frm_static_hit,
    output logic frm_dynamic_hit,
    output logic [NPORTS-1:0] frm_port_onehot
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NPORTS+58:0] f = '0;
    // one procedural owner for the strobe, idle low from time zero
    logic v = 1'b0;
    assign frm_valid = v;
    // one vector, so idle can show the inverse of the last frame
    assign {frm_etype, frm_src_port, frm_dst_port, frm_tcp_flags,
        frm_is_tcp, frm_is_l4, frm_is_ip, frm_static_hit,
        frm_dynamic_hit, frm_port_onehot} = f;
    // one frame on ingress port 0; fields hold only while valid
    task automatic send(input [15:0] et, s, d, input [5:0] fl,
        input [4:0] k);
        @(posedge clock);
        v <= 1'b1;
        f <= {et, s, d, fl, k, {{NPORTS-1{1'b0}}, 1'b1}};
        @(posedge clock);
        v <= 1'b0;
        f <= ~f;
        #1;
    endtask
endmodule

// ---- test/acsg_classifier_chk.sv ----
module acsg_classifier_chk #(
    parameter NPORTS = 4,
    parameter CW = 8
) (
    // watched ports
    input wire clock,
    input wire rst,
    input wire cfg_write,
    input wire cfg_etype_spec,
    input wire [15:0] cfg_etype_val,
    input wire entry_valid,
    input wire cfg_reject,
    input wire frm_valid,
    input wire res_valid,
    input wire guard_global_en,
    input wire [NPORTS-1:0] guard_port_en,
    input wire [2*NPORTS-1:0] guard_dyn_limit,
    input wire convert_cmd,
    input wire [NPORTS-1:0] learn_ok,
    input wire [NPORTS-1:0] guard_active,
    input wire [CW*NPORTS-1:0] dyn_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // specific writes while global enable is low, so no enable edge can clear the entry
    wire wr_spec = cfg_write && cfg_etype_spec && !guard_global_en;
    wire code_bad = cfg_etype_val == 16'h0800 ||
        cfg_etype_val == 16'h0806 || cfg_etype_val == 16'h86dd;
    sequence s_wr_low;
        wr_spec && cfg_etype_val < 16'h0600;
    endsequence
    sequence s_wr_code;
        wr_spec && code_bad;
    endsequence
    chk_res_follow: assert property (
        frm_valid |=> res_valid) else $error("no result");
    chk_low_etype: assert property (
        s_wr_low |=> cfg_reject && $stable(entry_valid))
        else $error("low ethertype taken");
    chk_code_refused: assert property (
        s_wr_code |=> cfg_reject && $stable(entry_valid))
        else $error("refused code taken");
    chk_en_clears: assert property (
        $rose(guard_global_en) |=> !entry_valid)
        else $error("entry kept");
    chk_active_and: assert property (
        guard_active == ({NPORTS{guard_global_en}} & guard_port_en))
        else $error("active wrong");
    chk_lim0_learn: assert property (
        guard_dyn_limit[1:0] == 2'h0 |-> !learn_ok[0])
        else $error("learn at zero");
    chk_lim1_full: assert property (
        guard_dyn_limit[1:0] == 2'h1 && dyn_count[CW-1:0] != 0
        |-> !learn_ok[0]) else $error("learn past limit");
    chk_convert_zero: assert property (
        convert_cmd |=> dyn_count == 0) else $error("count kept");
endmodule

// ---- test/acsg_classifier_tb_top.sv ----
module acsg_classifier_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam NP = 4;
    localparam [11:0] ANY = 12'haaa;
    logic clock = 0, rst = 1, cfg_write = 0, cfg_etype_spec = 0;
    logic guard_global_en = 0, convert_cmd = 0;
    logic [1:0] cfg_src_mode = 0, cfg_dst_mode = 0;
    logic [15:0] cfg_src_lo = 0, cfg_src_hi = 0, cfg_dst_lo = 0;
    logic [15:0] cfg_dst_hi = 0, cfg_etype_val = 0;
    logic [11:0] cfg_flag_sel = ANY;
    logic [NP-1:0] guard_port_en = 0, learn_req = 0, remove_req = 0;
    logic [2*NP-1:0] guard_dyn_limit = 0;
    wire entry_valid, cfg_reject, res_valid, res_match, res_forward;
    wire frm_valid, frm_is_tcp, frm_is_l4, frm_is_ip;
    wire frm_static_hit, frm_dynamic_hit;
    wire [15:0] frm_etype, frm_src_port, frm_dst_port;
    wire [5:0] frm_tcp_flags;
    wire [NP-1:0] frm_port_onehot, learn_ok, guard_active;
    wire [8*NP-1:0] dyn_count;
    int failures = 0, num_checks = 0;
    acsg_classifier #(.NPORTS(NP), .CW(8)) i_acsg_classifier (.*);
    acsg_pipe_model #(.NPORTS(NP)) i_acsg_pipe_model (.*);
    initial forever #50 clock = ~clock;
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [15:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one write pulse; c packs the entry fields in port order
    task automatic wr(input [96:0] c);
        @(posedge clock);
        cfg_write <= 1;
        {cfg_src_mode, cfg_src_lo, cfg_src_hi, cfg_dst_mode, cfg_dst_lo,
            cfg_dst_hi, cfg_flag_sel, cfg_etype_spec, cfg_etype_val} <= c;
        @(posedge clock);
        cfg_write <= 0;
        #1;
    endtask
    task automatic fr(input [15:0] et, s, d, input [5:0] fl,
        input [4:0] k, input logic m);
        i_acsg_pipe_model.send(et, s, d, fl, k);
        cmp(res_valid, 1, "valid");
        cmp(res_match, m, "match");
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_ports();
        wr({68'h0, ANY, 17'h0});
        fr(16'h0900, 16'h1234, 16'h4321, 6'h3f, 5'h18, 1);
        wr({2'h1, 16'h0050, 16'h0, 2'h2, 16'h0100, 16'h0200, ANY, 17'h0});
        fr(16'h0900, 16'h0050, 16'h0100, 0, 5'h18, 1);
        fr(16'h0900, 16'h0050, 16'h0200, 0, 5'h18, 1);
        fr(16'h0900, 16'h0051, 16'h0200, 0, 5'h18, 0);
        fr(16'h0900, 16'h0050, 16'h0201, 0, 5'h18, 0);
        fr(16'h0900, 16'h0050, 16'h0100, 0, 5'h00, 0);
        wr({2'h2, 16'h0010, 16'hffff, 2'h1, 16'hffff, 16'h0, ANY, 17'h0});
        fr(16'h0900, 16'hffff, 16'hffff, 0, 5'h18, 1);
        fr(16'h0900, 16'h000f, 16'hffff, 0, 5'h18, 0);
        fr(16'h0900, 16'h0010, 16'hfffe, 0, 5'h18, 0);
        // mode code 3 never matches; selector code 3 is a don't-care
        wr({2'h3, 16'h0, 16'hffff, 2'h0, 32'h0, ANY, 17'h0});
        fr(16'h0900, 0, 0, 6'h3f, 5'h18, 0);
        wr({68'h0, 12'hfff, 17'h0});
        fr(16'h0900, 0, 0, 6'h15, 5'h18, 1);
        $display("t_ports done");
    endtask
    // every flag, selector codes zero, one and any, flag clear and set
    task automatic t_flags();
        int b, s, v;
        logic [11:0] fs;
        for (int i = 0; i < 36; i++) begin
            b = i % 6;
            s = i / 12;
            v = i / 6 % 2;
            fs = ANY & ~(12'h3 << 2 * b) | 12'(s) << 2 * b;
            wr({68'h0, fs, 17'h0});
            fr(0, 0, 0, 6'(v) << b, 5'h18, s == 2 || s == v);
        end // share the loop above
        $display("t_flags done");
    endtask
    task automatic t_etype();
        logic [15:0] bad [4] = '{16'h05ff, 16'h0800, 16'h0806, 16'h86dd};
        wr({68'h0, ANY, 17'h0});
        fr(16'h0800, 0, 0, 0, 5'h18, 1);
        wr({68'h0, ANY, 1'b1, 16'h0600});
        cmp(cfg_reject, 0, "accept");
        fr(16'h0601, 0, 0, 0, 5'h18, 0);
        foreach (bad[i]) begin
            wr({68'h0, ANY, 1'b1, bad[i]});
            cmp(cfg_reject, 1, "refuse");
            fr(16'h0600, 0, 0, 0, 5'h18, 1);
        end
        wr({68'h0, ANY, 1'b1, 16'hffff});
        cmp(cfg_reject, 0, "accept again");
        fr(16'hffff, 0, 0, 0, 5'h18, 1);
        $display("t_etype done");
    endtask
    // limits 0 to unlimited, three learns each, convert between
    task automatic t_guard();
        @(posedge clock);
        guard_global_en <= 1;
        @(posedge clock);
        #1;
        cmp(entry_valid, 0, "cleared");
        for (int lim = 0; lim < 4; lim++) begin
            @(posedge clock);
            guard_port_en <= 1;
            guard_dyn_limit <= 8'(lim);
            convert_cmd <= 1;
            @(posedge clock);
            convert_cmd <= 0;
            learn_req <= 1;
            #1;
            cmp(dyn_count[7:0], 0, "convert");
            cmp(guard_active, 1, "active");
            for (int n = 0; n < 3; n++) begin
                #1;
                cmp(learn_ok[0], lim == 3 || n < lim, "learn");
                @(posedge clock);
            end
            learn_req <= 0;
            #1;
            cmp(dyn_count[7:0], lim == 3 ? 3 : lim, "count");
        end
        @(posedge clock);
        guard_dyn_limit <= 0;
        fr(16'h0800, 0, 0, 0, 5'h1d, 0);
        cmp(res_forward, 0, "dyn blocked");
        fr(16'h0800, 0, 0, 0, 5'h1e, 0);
        cmp(res_forward, 1, "static");
        $display("t_guard done");
    endtask
    // remove frees room under a limit of one; count 3 on entry
    task automatic t_remove();
        @(posedge clock);
        guard_dyn_limit <= 8'h01;
        remove_req <= 1;
        repeat (3) @(posedge clock);
        remove_req <= 0;
        learn_req <= 1;
        #1;
        cmp(dyn_count[7:0], 0, "removed");
        cmp(learn_ok[0], 1, "room again");
        @(posedge clock);
        #1;
        cmp(learn_ok[0], 0, "full again");
        @(posedge clock);
        guard_port_en <= 0;
        guard_dyn_limit <= 8'h03;
        #1;
        cmp(dyn_count[7:0], 1, "kept");
        cmp(learn_ok[0], 0, "inactive");
        @(posedge clock);
        guard_port_en <= 1;
        remove_req <= 1;
        @(posedge clock);
        learn_req <= 0;
        remove_req <= 0;
        #1;
        cmp(dyn_count[7:0], 1, "learn and remove");
        $display("t_remove done");
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 0;
        t_ports();
        t_flags();
        t_etype();
        t_guard();
        t_remove();
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        give_verdict();
    end
endmodule
bind acsg_classifier acsg_classifier_chk #(.NPORTS(NPORTS), .CW(CW))
    i_acsg_classifier_chk (.*);
